// [dsc_top.sv]
/*
 * Dual converter serial control: three-wire link with readback, clear,
 * load and reset flag, and fixed-range span selection by strap pins.
 * Assumes the host frames each instruction with select_load_n and keeps
 * serial_clock still while select_load_n is high.
 */
`timescale 1ns/10ps
`include "dsc_defs.svh"
module dsc_top
  import dsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic serial_clock,
  input wire logic select_load_n,
  input wire logic serial_in,
  output logic readback_out,
  output logic readback_oe_n,
  input wire logic async_clear_n,
  input wire logic async_load_n,
  input wire logic fixed_span_mode,
  input wire logic span_strap_bit0,
  input wire logic span_strap_bit1,
  input wire logic span_strap_bit2,
  output logic reset_flag_n,
  output logic [17:0] dac_code_a,
  output logic [17:0] dac_code_b,
  output logic [2:0] active_span_a,
  output logic [2:0] active_span_b
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic link_rst;
  logic [5:0] bit_cnt;
  logic [5:0] frame_len;
  logic [31:0] frame;
  logic frame_tog;
  logic [23:0] ro_word;
  logic [6:0] sync_q;
  logic sel_s;
  logic ld_s;
  logic cs_s;
  logic ld_n_s;
  logic mode_s;
  dsc_span_type strap_s;
  logic tog_s;
  logic tog_seen;
  logic cs_prev;
  logic exec;
  logic load_upd;
  dsc_nibble_type cmd;
  dsc_nibble_type addr;
  dsc_code_type in_code [2];
  dsc_span_type in_span [2];
  dsc_code_type dac_code [2];
  dsc_span_type dac_span [2];
  dsc_span_type act_span [2];
  logic [1:0] upd;
  logic [23:0] rb_word;

  function automatic logic dsc_hit(input dsc_nibble_type a, input int ch);
    dsc_hit = (a == dsc_nibble_type'(ch)) || (a == `DSC_ADDR_ALL);
  endfunction

  // ----------------------------------------
  // Link side, serial clock domain
  // ----------------------------------------
  // Frame length and token are cleared from a flop, so they need no serial clock edge
  always_ff @(posedge clk_sys) begin
    link_rst <= !rstn;
  end

  always_ff @(posedge serial_clock or posedge select_load_n) begin
    if (select_load_n) begin
      bit_cnt <= 6'h00;
    end else if (bit_cnt != `DSC_CNT_MAX) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  always_ff @(posedge serial_clock) begin
    if (!select_load_n) begin
      frame <= {frame[30:0], serial_in};
    end
  end

  // Length and frame token survive the select rise for the system side
  always_ff @(posedge serial_clock or posedge link_rst) begin
    if (link_rst) begin
      frame_len <= 6'h00;
      frame_tog <= 1'b0;
    end else if (!select_load_n) begin
      frame_len <= (bit_cnt == `DSC_CNT_MAX) ? bit_cnt : bit_cnt + 6'h01;
      if (bit_cnt == 6'h00) begin
        frame_tog <= !frame_tog;
      end
    end
  end

  // Registers read here are quiet during a frame, so no crossing needed
  always_comb begin
    rb_word = '0;
    // Walk downwards so the lowest channel wins for the broadcast address
    for (int ch = 1; ch >= 0; ch--) begin
      if (dsc_hit(frame[3:0], ch)) begin
        rb_word = {in_code[ch], 3'h0, in_span[ch]};
      end
    end
  end

  always_ff @(negedge serial_clock or posedge select_load_n) begin
    if (select_load_n) begin
      ro_word <= '0;
    end else if (bit_cnt == `DSC_CNT_ADDR_DONE) begin
      ro_word <= rb_word;
    end else if (bit_cnt > `DSC_CNT_ADDR_DONE) begin
      ro_word <= {ro_word[22:0], 1'b0};
    end
  end

  assign readback_out = ro_word[23];

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // straps sampled continuously
  // Select and load enter inverted so the flops' reset value reads as idle
  dsc_sync #(.W(7)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d({~select_load_n, ~async_load_n, fixed_span_mode, span_strap_bit2,
        span_strap_bit1, span_strap_bit0, frame_tog}),
    .q(sync_q)
  );

  assign {sel_s, ld_s, mode_s, strap_s, tog_s} = sync_q;
  assign cs_s = ~sel_s;
  assign ld_n_s = ~ld_s;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      readback_oe_n <= 1'b1;
    end else begin
      readback_oe_n <= cs_s;
    end
  end

  // ----------------------------------------
  // Instruction execution
  // ----------------------------------------
  // exact length only
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cs_prev <= 1'b1;
      tog_seen <= 1'b0;
    end else begin
      cs_prev <= cs_s;
      if (cs_s && !cs_prev) begin
        tog_seen <= tog_s;
      end
    end
  end

  assign exec = cs_s && !cs_prev && (tog_s != tog_seen) && (frame_len == `DSC_CNT_FRAME);
  assign cmd = frame[`DSC_CMD_HI:`DSC_CMD_LO];
  assign addr = frame[`DSC_ADDR_HI:`DSC_ADDR_LO];
  assign load_upd = !ld_n_s && cs_s;

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      assign upd[ch] = load_upd || (exec && dsc_hit(addr, ch) &&
        (cmd == `DSC_CMD_UPDATE || cmd == `DSC_CMD_WR_SPAN_UPD ||
         cmd == `DSC_CMD_WR_CODE_UPD));

      dsc_code_type next_code;
      dsc_span_type next_span;

      // code field MSB first
      // Write with update hands the new word straight to the converter
      always_comb begin
        next_code = in_code[ch];
        next_span = in_span[ch];
        if (exec && dsc_hit(addr, ch)) begin
          if (cmd == `DSC_CMD_WR_CODE || cmd == `DSC_CMD_WR_CODE_UPD) begin
            next_code = frame[`DSC_CODE_HI:`DSC_CODE_LO];
          end
          if (cmd == `DSC_CMD_WR_SPAN || cmd == `DSC_CMD_WR_SPAN_UPD) begin
            next_span = frame[`DSC_SPAN_HI:`DSC_SPAN_LO];
          end
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!rstn) begin
          in_code[ch] <= `DSC_CODE_RST;
          in_span[ch] <= `DSC_SPAN_RST;
        end else begin
          in_code[ch] <= next_code;
          in_span[ch] <= next_span;
        end
      end

      always_ff @(posedge clk_sys or negedge async_clear_n) begin
        if (!async_clear_n) begin
          dac_code[ch] <= `DSC_CODE_RST;
          dac_span[ch] <= `DSC_SPAN_RST;
          act_span[ch] <= `DSC_SPAN_RST;
        end else if (!rstn) begin
          dac_code[ch] <= `DSC_CODE_RST;
          dac_span[ch] <= `DSC_SPAN_RST;
          act_span[ch] <= `DSC_SPAN_RST;
        end else begin
          if (upd[ch]) begin
            dac_code[ch] <= next_code;
            dac_span[ch] <= next_span;
          end
          act_span[ch] <= mode_s ? strap_s : dac_span[ch];
        end
      end
    end
  endgenerate

  assign dac_code_a = dac_code[0];
  assign dac_code_b = dac_code[1];
  assign active_span_a = act_span[0];
  assign active_span_b = act_span[1];

  // ----------------------------------------
  // Reset flag
  // ----------------------------------------
  // low at reset or clear
  always_ff @(posedge clk_sys or negedge async_clear_n) begin
    if (!async_clear_n) begin
      reset_flag_n <= 1'b0;
    end else if (!rstn) begin
      reset_flag_n <= 1'b0;
    end else if (upd != 2'b00) begin
      reset_flag_n <= 1'b1;
    end
  end
endmodule

// [dsc_defs.svh]
/*
 * Constants for the dual converter serial control block: frame layout,
 * command codes, address codes, field positions and reset values.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define DSC_FRAME_BITS 32
`define DSC_CNT_MAX 6'h3F
`define DSC_CNT_FRAME 6'h20
`define DSC_CNT_ADDR_DONE 6'h08
`define DSC_CMD_HI 31
`define DSC_CMD_LO 28
`define DSC_ADDR_HI 27
`define DSC_ADDR_LO 24
`define DSC_CODE_HI 23
`define DSC_CODE_LO 6
`define DSC_SPAN_HI 2
`define DSC_SPAN_LO 0

// ----------------------------------------
// Command and address codes
// ----------------------------------------
`define DSC_CMD_WR_SPAN 4'h2
`define DSC_CMD_WR_CODE 4'h3
`define DSC_CMD_UPDATE 4'h4
`define DSC_CMD_WR_SPAN_UPD 4'h6
`define DSC_CMD_WR_CODE_UPD 4'h7
`define DSC_ADDR_ALL 4'hF

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DSC_CODE_RST 18'h00000
`define DSC_SPAN_RST 3'h0

`endif

// [dsc_pkg.sv]
/*
 * Types shared by the dual converter serial control block.
 * Assumes nothing of its surroundings.
 */
package dsc_pkg;
  typedef logic [17:0] dsc_code_type;
  typedef logic [2:0] dsc_span_type;
  typedef logic [3:0] dsc_nibble_type;
endpackage

// [dsc_sync.sv]
/*
 * Two-flop level synchroniser, one per bit.
 * Assumes each input bit is a level that holds for several clocks.
 */
`timescale 1ns/10ps
module dsc_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// [dsc_top_asserts.sv]
/*
 * Checker for the dual converter serial control top level.
 * Assumes it is bound to dsc_top and sees only its ports.
 */
`timescale 1ns/10ps
module dsc_top_asserts
  import dsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic serial_clock,
  input wire logic select_load_n,
  input wire logic serial_in,
  input wire logic readback_out,
  input wire logic readback_oe_n,
  input wire logic async_clear_n,
  input wire logic async_load_n,
  input wire logic fixed_span_mode,
  input wire logic span_strap_bit0,
  input wire logic span_strap_bit1,
  input wire logic span_strap_bit2,
  input wire logic reset_flag_n,
  input wire logic [17:0] dac_code_a,
  input wire logic [17:0] dac_code_b,
  input wire logic [2:0] active_span_a,
  input wire logic [2:0] active_span_b
);
  logic [2:0] strap;
  assign strap = {span_strap_bit2, span_strap_bit1, span_strap_bit0};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Long enough for the select and load synchronisers to settle
  sequence s_quiet8;
    (select_load_n && async_load_n && async_clear_n)[*8];
  endsequence
  sequence s_fixed6;
    (fixed_span_mode && async_clear_n && $stable(strap))[*6];
  endsequence
  a_oe_idle: assert property (select_load_n[*5] |-> readback_oe_n)
    else $error("readback driven while deselected");
  a_oe_frame: assert property ((!select_load_n)[*5] |-> !readback_oe_n)
    else $error("readback not driven in frame");
  a_clear_zero: assert property (!async_clear_n |->
      {dac_code_a, dac_code_b, active_span_a, active_span_b} == 42'h0)
    else $error("clear left a register set");
  a_clear_flag: assert property (!async_clear_n |-> !reset_flag_n)
    else $error("flag high during clear");
  a_flag_hold: assert property (s_quiet8 ##0 !reset_flag_n |=> !reset_flag_n)
    else $error("flag rose without update");
  a_load_flag: assert property (
      (!async_load_n && select_load_n && async_clear_n)[*5] |-> reset_flag_n)
    else $error("load pin did not update");
  a_fixed_span: assert property (s_fixed6 |->
      active_span_a == strap && active_span_b == strap)
    else $error("span differs from straps");
  a_code_hold: assert property (s_quiet8 |=> $stable({dac_code_a, dac_code_b}) &&
      (fixed_span_mode || $stable({active_span_a, active_span_b})))
    else $error("output changed without update");
endmodule
bind dsc_top dsc_top_asserts dsc_top_asserts_i (.clk_sys, .rstn, .serial_clock,
  .select_load_n, .serial_in, .readback_out, .readback_oe_n, .async_clear_n,
  .async_load_n, .fixed_span_mode, .span_strap_bit0, .span_strap_bit1,
  .span_strap_bit2, .reset_flag_n, .dac_code_a, .dac_code_b, .active_span_a,
  .active_span_b);

// [dsc_host.sv]
/*
 * Host model driving the three-wire link with a 12 ns serial clock.
 * Assumes the caller spaces frames; the clock stays low between frames.
 */
`timescale 1ns/10ps
module dsc_host (
  output logic serial_clock,
  output logic select_load_n,
  output logic serial_in,
  input wire logic readback_out,
  input wire logic readback_oe_n
);
  initial begin
    serial_clock = 1'b0;
    select_load_n = 1'b1;
    serial_in = 1'b0;
  end
  // word sent most significant bit first
  task automatic xfer(input logic [31:0] w, input int n, output logic [23:0] rb);
    rb = 24'h000000;
    select_load_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      // bit set half a period before the rise
      serial_in = w[31-i];
      #6 serial_clock = 1'b1;
      // Undriven line modelled as the inverse of the last bit
      if (i >= 8) rb = {rb[22:0], readback_oe_n ? ~readback_out : readback_out};
      #6 serial_clock = 1'b0;
    end
    #6 select_load_n = 1'b1;
    // Released line must not keep the last bit
    serial_in = ~serial_in;
  endtask
endmodule

// [tb_top.sv]
/*
 * Self-checking bench for the dual converter serial control block.
 * Assumes dsc_host as link partner and the bound checker.
 */
`timescale 1ns/10ps
module tb_top;
  import dsc_pkg::*;
  localparam dsc_code_type CODE_A = 18'h2A5C3;
  localparam dsc_code_type CODE_B = 18'h15A3C;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic async_clear_n = 1'b1;
  logic async_load_n = 1'b1;
  logic fixed_span_mode = 1'b0;
  logic [2:0] strap = 3'h2;
  logic [23:0] rb;
  logic sck, sel, sin, rbo, rboe, rfl;
  logic [17:0] ca, cb;
  logic [2:0] sa, sb;
  int err_total = 0;
  int checked = 0;
  always #5 clk_sys = ~clk_sys;
  dsc_host dsc_host_i (.serial_clock(sck), .select_load_n(sel), .serial_in(sin),
    .readback_out(rbo), .readback_oe_n(rboe));
  dsc_top dsc_top_i (.clk_sys(clk_sys), .rstn(rstn), .serial_clock(sck),
    .select_load_n(sel), .serial_in(sin), .readback_out(rbo), .readback_oe_n(rboe),
    .async_clear_n(async_clear_n), .async_load_n(async_load_n),
    .fixed_span_mode(fixed_span_mode), .span_strap_bit0(strap[0]),
    .span_strap_bit1(strap[1]), .span_strap_bit2(strap[2]), .reset_flag_n(rfl),
    .dac_code_a(ca), .dac_code_b(cb), .active_span_a(sa), .active_span_b(sb));
  task chk(input string nm, input logic [23:0] s, input logic [23:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Eight clocks cover the sync and update latency
  task go(input logic [31:0] w, input int n);
    dsc_host_i.xfer(w, n, rb);
    repeat (8) @(negedge clk_sys);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk("flag", rfl, 1'b0);
    go({4'h3, 4'h0, CODE_A, 6'h00}, 32);
    chk("code_a", ca, 18'h0);
    chk("flag", rfl, 1'b0);
    go({4'h4, 4'hF, 24'h0}, 32);
    chk("code_a", ca, CODE_A);
    chk("flag", rfl, 1'b1);
    go({4'h7, 4'h1, CODE_B, 6'h00}, 32);
    chk("code_b", cb, CODE_B);
    go({4'h0, 4'h0, 24'h0}, 32);
    chk("readback", rb, {CODE_A, 6'h00});
    go({4'h6, 4'hF, 21'h0, 3'h4}, 32);
    chk("span_a", sa, 3'h4);
    chk("span_b", sb, 3'h4);
    // One bit short; a length-blind decode would write CODE_B into channel A
    go({3'h7, 4'h0, CODE_B, 6'h00, 1'b0}, 31);
    chk("code_a", ca, CODE_A);
    fixed_span_mode = 1'b1;
    strap = 3'h6;
    repeat (8) @(negedge clk_sys);
    chk("span_a", sa, 3'h6);
    go({4'h6, 4'hF, 21'h0, 3'h1}, 32);
    chk("span_b", sb, 3'h6);
    async_clear_n = 1'b0;
    #2;
    chk("code_b", cb, 18'h0);
    chk("flag", rfl, 1'b0);
    repeat (3) @(negedge clk_sys);
    async_clear_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    async_load_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    async_load_n = 1'b1;
    chk("flag", rfl, 1'b1);
    chk("code_a", ca, CODE_A);
    tally_and_finish;
  end
endmodule
